// ===== hdl/cpsc_ctrl.sv
// CPU power state controller: the device end of the power interface.
//
// Overview of operation
// - Reset enters the full-power active state.
// - Five numbered states; higher means more current.
// - Active mode allows four states.
// - Full-power state gives every CPU function.
// - Reduced-voltage state keeps functions, lower supply.
// - Low-voltage state: limited functions, much lower supply.
// - CPU-off state; peripherals configured beforehand.
// - Wait-for-interrupt enters standby; CPU clock gated.
// - Standby keeps SRAM at originating active level.
// - Any interrupt wakes from standby.
// - Sleep request powers the CPU off.
// - Sleep keeps always-on domain, may retain SRAM.
// - Deep sleep from any active state.
// - Deep sleep power-gates CPU, no SRAM retention.
// - Leaving active needs a software request.
// - Only enabled wake sources end sleep and deep sleep.
// - Low power allowed only with matching netproc state.
// - Low-voltage with busy netproc is unsupported.
// - Netproc flag set keeps the CPU awake.
// - CPU flag set keeps the netproc awake.
`include "cpsc_regs.svh"
module cpsc_ctrl
  import cpsc_pkg::*;
#(
  parameter int WAKE_W = `CPSC_WAKE_W
) (
  input  wire logic              CORE_CLK,
  input  wire logic              RESETN,
  cpsc_if.ctrl                   pif,
  input  wire logic [WAKE_W-1:0] WAKE_IRQ,
  input  wire logic [`CPSC_NP_W-1:0] NETPROC_STATE,
  input  wire logic              NETPROC_WANTS_CPU_AWAKE,
  output logic                   UNSUPPORTED,
  output logic [`CPSC_PS_W-1:0]  SRAM_LEVEL_PS,
  output logic                   ALWAYS_ON_EN,
  output logic                   BATTERY_DOMAIN_GPIO_EN,
  output logic                   PERIPH_EN
);
  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------
  localparam int SW = WAKE_W + `CPSC_NP_W + 1;
  logic [SW-1:0]         sync_q;
  logic [WAKE_W-1:0]     irq_s;
  logic [`CPSC_NP_W-1:0] np_s;
  logic                  np_hold_s;

  if (WAKE_W != `CPSC_WAKE_W) begin : g_bad_wake
    $error("cpsc_ctrl: WAKE_W must match bus");
  end

  cpsc_sync #(.W(SW)) u_sync (
    .CORE_CLK (CORE_CLK),
    .RESETN   (RESETN),
    .d        ({WAKE_IRQ, NETPROC_STATE, NETPROC_WANTS_CPU_AWAKE}),
    .q        (sync_q)
  );
  assign irq_s     = sync_q[SW-1 -: WAKE_W];
  assign np_s      = sync_q[`CPSC_NP_W:1];
  assign np_hold_s = sync_q[0];

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  cpsc_mode_t                mode_r, mode_nxt;
  logic [`CPSC_PS_W-1:0]     ps_r, ps_nxt;
  logic [`CPSC_PS_W-1:0]     home_r, home_nxt;
  logic [WAKE_W-1:0]         arm_r, arm_nxt;
  logic                      ack_r, ack_nxt;
  logic                      nack_r, nack_nxt;
  logic                      unsup_r, unsup_nxt;
  logic                      cwn_r, cwn_nxt;
  logic                      clk_en_r, pwr_en_r, ret_r, per_r;
  logic                      clk_en_nxt, pwr_en_nxt, ret_nxt, per_nxt;
  logic                      lp_ok_sb, lp_ok_deep, act_ps_ok, wake;

  // Standby and sleep need a connected netproc or an unconnected one with retention.
  assign lp_ok_sb   = (np_s == `CPSC_NP_CONN) ||
                      (np_s == `CPSC_NP_UNC_RET);
  assign lp_ok_deep = (np_s == `CPSC_NP_UNC_NORET);
  assign act_ps_ok  = (pif.req_ps >= `CPSC_PS_CPUOFF) &&
                      (pif.req_ps <= `CPSC_PS_FULL);
  assign wake       = |(irq_s & arm_r);

  always_comb begin
    mode_nxt  = mode_r;
    ps_nxt    = ps_r;
    home_nxt  = home_r;
    arm_nxt   = arm_r;
    ack_nxt   = 1'b0;
    nack_nxt  = 1'b0;
    unique case (mode_r)
      CPSC_MODE_ACTIVE: begin
        if (pif.wfi && ps_r != `CPSC_PS_CPUOFF) begin
          // Any interrupt wakes standby, so all sources are armed.
          if (lp_ok_sb && !np_hold_s) begin
            mode_nxt = CPSC_MODE_STANDBY;
            home_nxt = ps_r;
            arm_nxt  = '1;
          end
        end else if (pif.req_valid) begin
          unique case (pif.req_kind)
            `CPSC_REQ_ACTIVE: begin
              if (act_ps_ok && pif.periph_cfg_done) begin
                ps_nxt  = pif.req_ps;
                home_nxt = pif.req_ps;
                ack_nxt = 1'b1;
              end else begin
                nack_nxt = 1'b1;
              end
            end
            `CPSC_REQ_SLEEP: begin
              if (lp_ok_sb && !np_hold_s && ps_r != `CPSC_PS_CPUOFF &&
                  |pif.wake_en) begin
                mode_nxt = CPSC_MODE_SLEEP;
                home_nxt = ps_r;
                arm_nxt  = pif.wake_en;
                ack_nxt  = 1'b1;
              end else begin
                nack_nxt = 1'b1;
              end
            end
            `CPSC_REQ_DEEP: begin
              if (lp_ok_deep && !np_hold_s && pif.periph_cfg_done &&
                  |pif.wake_en) begin
                mode_nxt = CPSC_MODE_DEEP;
                home_nxt = `CPSC_PS_FULL;
                ps_nxt   = `CPSC_PS_DEEP;
                arm_nxt  = pif.wake_en;
                ack_nxt  = 1'b1;
              end else begin
                nack_nxt = 1'b1;
              end
            end
            default: nack_nxt = 1'b1;
          endcase
        end
      end
      CPSC_MODE_STANDBY, CPSC_MODE_SLEEP, CPSC_MODE_DEEP: begin
        if (wake) begin
          mode_nxt = CPSC_MODE_ACTIVE;
          ps_nxt   = home_r;
          arm_nxt  = '0;
        end
      end
    endcase
    // Enables derive from the next state so outputs track it directly.
    clk_en_nxt = (mode_nxt == CPSC_MODE_ACTIVE) &&
                 (ps_nxt != `CPSC_PS_CPUOFF);
    pwr_en_nxt = (mode_nxt == CPSC_MODE_ACTIVE ||
                  mode_nxt == CPSC_MODE_STANDBY) &&
                 (ps_nxt != `CPSC_PS_CPUOFF);
    ret_nxt    = (mode_nxt != CPSC_MODE_DEEP);
    per_nxt    = (mode_nxt == CPSC_MODE_ACTIVE ||
                  mode_nxt == CPSC_MODE_STANDBY);
    unsup_nxt  = (ps_nxt == `CPSC_PS_LOWV) &&
                 (np_s == `CPSC_NP_ACTIVE ||
                  np_s == `CPSC_NP_CONN);
    cwn_nxt    = (mode_nxt == CPSC_MODE_ACTIVE) &&
                 (ps_nxt != `CPSC_PS_CPUOFF);
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      mode_r   <= CPSC_MODE_ACTIVE;
      ps_r     <= `CPSC_PS_FULL;
      home_r   <= `CPSC_PS_FULL;
      arm_r    <= '0;
      ack_r    <= 1'b0;
      nack_r   <= 1'b0;
      unsup_r  <= 1'b0;
      cwn_r    <= 1'b1;
      clk_en_r <= 1'b1;
      pwr_en_r <= 1'b1;
      ret_r    <= 1'b1;
      per_r    <= 1'b1;
    end else begin
      mode_r   <= mode_nxt;
      ps_r     <= ps_nxt;
      home_r   <= home_nxt;
      arm_r    <= arm_nxt;
      ack_r    <= ack_nxt;
      nack_r   <= nack_nxt;
      unsup_r  <= unsup_nxt;
      cwn_r    <= cwn_nxt;
      clk_en_r <= clk_en_nxt;
      pwr_en_r <= pwr_en_nxt;
      ret_r    <= ret_nxt;
      per_r    <= per_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // SRAM level follows the originating active state in standby and sleep; deep sleep sets it to full power.
  assign SRAM_LEVEL_PS = home_r;
  assign pif.req_ack   = ack_r;
  assign pif.req_nack  = nack_r;
  assign pif.cur_ps    = ps_r;
  assign pif.cur_mode  = mode_r;
  assign pif.cpu_clk_en  = clk_en_r;
  assign pif.cpu_pwr_en  = pwr_en_r;
  assign pif.sram_retain = ret_r;
  assign pif.cpu_wants_netproc_awake = cwn_r;
  assign UNSUPPORTED   = unsup_r;
  assign ALWAYS_ON_EN  = 1'b1;
  assign BATTERY_DOMAIN_GPIO_EN = 1'b1;
  assign PERIPH_EN     = per_r;
endmodule

// ===== hdl/cpsc_sw.sv
// Software agent end: issues power requests on behalf of the CPU.
`include "cpsc_regs.svh"
module cpsc_sw
  import cpsc_pkg::*;
(
  input  wire logic                   CORE_CLK,
  input  wire logic                   RESETN,
  cpsc_if.sw                          pif,
  input  wire logic                   CMD_VALID,
  input  wire logic [`CPSC_REQ_W-1:0] CMD_KIND,
  input  wire logic [`CPSC_PS_W-1:0]  CMD_PS,
  input  wire logic [`CPSC_WAKE_W-1:0] CMD_WAKE_EN,
  input  wire logic                   CMD_CFG_DONE,
  output logic                        CMD_BUSY,
  output logic                        CMD_DONE,
  output logic                        CMD_FAIL
);
  logic [`CPSC_REQ_W-1:0]  kind_r, kind_nxt;
  logic [`CPSC_PS_W-1:0]   ps_r, ps_nxt;
  logic [`CPSC_WAKE_W-1:0] wen_r, wen_nxt;
  logic cfg_r, cfg_nxt, valid_r, valid_nxt, wfi_r, wfi_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt, fail_r, fail_nxt;

  // Wake enables and configuration are latched on the same edge as the request.
  always_comb begin
    kind_nxt  = kind_r;
    ps_nxt    = ps_r;
    wen_nxt   = wen_r;
    cfg_nxt   = cfg_r;
    valid_nxt = 1'b0;
    wfi_nxt   = 1'b0;
    done_nxt  = 1'b0;
    fail_nxt  = 1'b0;
    busy_nxt  = busy_r;
    if (busy_r) begin
      if (kind_r == `CPSC_REQ_STANDBY) begin
        // The wfi pulse is taken at the next edge; judge the mode after it.
        if (!wfi_r) begin
          busy_nxt = 1'b0;
          done_nxt = (pif.cur_mode != CPSC_MODE_ACTIVE);
          fail_nxt = (pif.cur_mode == CPSC_MODE_ACTIVE);
        end
      end else if (pif.req_ack || pif.req_nack) begin
        busy_nxt = 1'b0;
        done_nxt = pif.req_ack;
        fail_nxt = pif.req_nack;
      end
    end else if (CMD_VALID) begin
      kind_nxt = CMD_KIND;
      ps_nxt   = CMD_PS;
      wen_nxt  = CMD_WAKE_EN;
      cfg_nxt  = CMD_CFG_DONE;
      busy_nxt = 1'b1;
      if (CMD_KIND == `CPSC_REQ_STANDBY) begin
        wfi_nxt = 1'b1;
      end else begin
        valid_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      kind_r  <= `CPSC_REQ_NONE;
      ps_r    <= `CPSC_PS_FULL;
      wen_r   <= '0;
      cfg_r   <= 1'b0;
      valid_r <= 1'b0;
      wfi_r   <= 1'b0;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
      fail_r  <= 1'b0;
    end else begin
      kind_r  <= kind_nxt;
      ps_r    <= ps_nxt;
      wen_r   <= wen_nxt;
      cfg_r   <= cfg_nxt;
      valid_r <= valid_nxt;
      wfi_r   <= wfi_nxt;
      busy_r  <= busy_nxt;
      done_r  <= done_nxt;
      fail_r  <= fail_nxt;
    end
  end

  assign pif.req_kind  = kind_r;
  assign pif.req_ps    = ps_r;
  assign pif.req_valid = valid_r;
  assign pif.wake_en   = wen_r;
  assign pif.wfi       = wfi_r;
  assign pif.periph_cfg_done = cfg_r;
  assign CMD_BUSY = busy_r;
  assign CMD_DONE = done_r;
  assign CMD_FAIL = fail_r;
endmodule

// ===== hdl/cpsc_sync.sv
// Three-stage synchroniser for a bus of asynchronous inputs.
module cpsc_sync #(
  parameter int W = 1
) (
  input  wire logic         CORE_CLK,
  input  wire logic         RESETN,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  if (W < 1) begin : g_bad_width
    $error("cpsc_sync: W must be at least 1");
  end

  // A bit changes only once the second and third stages agree.
  always_comb begin
    q_nxt = q_r;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i]) q_nxt[i] = s3_r[i];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end

  assign q = q_r;
endmodule

// ===== shared/cpsc_if.sv
// Interface joining the power state controller and its software agent.
`include "cpsc_regs.svh"
interface cpsc_if;
  logic [`CPSC_REQ_W-1:0]  req_kind;
  logic [`CPSC_PS_W-1:0]   req_ps;
  logic                    req_valid;
  logic [`CPSC_WAKE_W-1:0] wake_en;
  logic                    wfi;
  logic                    req_ack;
  logic                    req_nack;
  logic [`CPSC_PS_W-1:0]   cur_ps;
  logic [1:0]              cur_mode;
  logic                    cpu_clk_en;
  logic                    cpu_pwr_en;
  logic                    sram_retain;
  logic                    periph_cfg_done;
  logic                    cpu_wants_netproc_awake;
  modport ctrl (
    input  req_kind, req_ps, req_valid, wake_en, wfi, periph_cfg_done,
    output req_ack, req_nack, cur_ps, cur_mode, cpu_clk_en, cpu_pwr_en,
           sram_retain, cpu_wants_netproc_awake
  );
  modport sw (
    output req_kind, req_ps, req_valid, wake_en, wfi, periph_cfg_done,
    input  req_ack, req_nack, cur_ps, cur_mode, cpu_clk_en, cpu_pwr_en,
           sram_retain, cpu_wants_netproc_awake
  );
endinterface

// ===== shared/cpsc_pkg.sv
// Types shared by the CPU power state controller ends.
package cpsc_pkg;
  typedef enum logic [1:0] {
    CPSC_MODE_ACTIVE  = 2'b00,
    CPSC_MODE_STANDBY = 2'b01,
    CPSC_MODE_SLEEP   = 2'b10,
    CPSC_MODE_DEEP    = 2'b11
  } cpsc_mode_t;
endpackage

// ===== shared/cpsc_regs.svh
// Constant definitions for the CPU power state controller.
`ifndef CPSC_REGS_SVH
`define CPSC_REGS_SVH

`define CPSC_PS_W        3
`define CPSC_PS_DEEP     3'h0
`define CPSC_PS_CPUOFF   3'h1
`define CPSC_PS_LOWV     3'h2
`define CPSC_PS_REDV     3'h3
`define CPSC_PS_FULL     3'h4
`define CPSC_REQ_W       3
`define CPSC_REQ_NONE    3'h0
`define CPSC_REQ_ACTIVE  3'h1
`define CPSC_REQ_STANDBY 3'h2
`define CPSC_REQ_SLEEP   3'h3
`define CPSC_REQ_DEEP    3'h4
`define CPSC_NP_W        2
`define CPSC_NP_ACTIVE   2'h0
`define CPSC_NP_CONN     2'h1
`define CPSC_NP_UNC_RET  2'h2
`define CPSC_NP_UNC_NORET 2'h3
`define CPSC_WAKE_W      8
`define CPSC_SYNC_LEN    3

`endif

// ===== tb/cpsc_props.sv
// Concurrent checks on the interface joining the two controller ends.
`include "cpsc_regs.svh"
module cpsc_props (
  input wire logic                   CORE_CLK,
  input wire logic                   RESETN,
  input wire logic [`CPSC_REQ_W-1:0] req_kind,
  input wire logic                   req_valid,
  input wire logic                   wfi,
  input wire logic                   req_ack,
  input wire logic                   req_nack,
  input wire logic [`CPSC_PS_W-1:0]  cur_ps,
  input wire logic [1:0]             cur_mode,
  input wire logic                   cpu_clk_en,
  input wire logic                   cpu_pwr_en,
  input wire logic                   sram_retain,
  input wire logic                   cpu_wants_netproc_awake
);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  property p_reset_full;
    $rose(RESETN) |-> cur_ps == `CPSC_PS_FULL && cur_mode == 2'h0;
  endproperty
  property p_answer;
    req_valid && cur_mode == 2'h0 |=> req_ack != req_nack;
  endproperty
  property p_ack_pulse;
    req_ack |=> !req_ack;
  endproperty
  property p_quiet;
    cur_mode == 2'h0 && !req_valid && !wfi |=> cur_mode == 2'h0;
  endproperty
  property p_standby;
    cur_mode == 2'h1 |-> !cpu_clk_en && cpu_pwr_en;
  endproperty
  property p_sleep;
    cur_mode == 2'h2 |-> !cpu_clk_en && !cpu_pwr_en;
  endproperty
  property p_deep;
    cur_mode == 2'h3 |-> !cpu_pwr_en && !sram_retain && cur_ps == 3'h0;
  endproperty
  property p_active_ps;
    cur_mode == 2'h0 |-> cur_ps inside {[3'h1:3'h4]};
  endproperty
  property p_ps_max;
    cur_ps <= `CPSC_PS_FULL;
  endproperty
  property p_no_sleep_ps1;
    req_valid && req_kind == 3'h3 && cur_ps == 3'h1 && cur_mode == 2'h0
      |=> req_nack;
  endproperty
  property p_cwn;
    cpu_wants_netproc_awake == (cur_mode == 2'h0 && cur_ps != 3'h1);
  endproperty
  a_reset_full: assert property (p_reset_full)
    else $error("reset state wrong");
  a_answer: assert property (p_answer)
    else $error("request not answered once");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  a_quiet: assert property (p_quiet)
    else $error("left active without request");
  a_standby: assert property (p_standby)
    else $error("standby enables wrong");
  a_sleep: assert property (p_sleep)
    else $error("sleep enables wrong");
  a_deep: assert property (p_deep)
    else $error("deep sleep outputs wrong");
  a_active_ps: assert property (p_active_ps)
    else $error("active state out of range");
  a_ps_max: assert property (p_ps_max)
    else $error("state number too high");
  a_no_sleep_ps1: assert property (p_no_sleep_ps1)
    else $error("sleep from cpu-off accepted");
  a_cwn: assert property (p_cwn)
    else $error("netproc hold flag wrong");
  c_standby: cover property (cur_mode == 2'h1);
  c_sleep: cover property (cur_mode == 2'h2);
  c_deep: cover property (cur_mode == 2'h3);
endmodule

// ===== tb/cpu_power_state_controller_tb.sv
// Self-checking bench joining the controller and the software end.
module cpu_power_state_controller_tb import cpsc_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       cmd_valid = 1'b0;
  logic       cfg = 1'b1;
  logic       hold = 1'b0;
  logic [2:0] kind = 3'h1;
  logic [2:0] ps = 3'h4;
  logic [7:0] wake = 8'h01;
  logic [7:0] irq = 8'h00;
  logic [1:0] np = 2'h1;
  logic       busy, done, fail, unsup, aon, bgpio, pen;
  logic [2:0] sram_lvl, model_ps;
  int         seed = 74217;
  int         error_cnt = 0;
  int         n_tests = 0;
  always #5 clk = ~clk;
  cpsc_if i_cpsc_if ();
  cpsc_ctrl i_cpsc_ctrl (.CORE_CLK(clk), .RESETN(rst_n), .pif(i_cpsc_if),
    .WAKE_IRQ(irq), .NETPROC_STATE(np), .NETPROC_WANTS_CPU_AWAKE(hold),
    .UNSUPPORTED(unsup), .SRAM_LEVEL_PS(sram_lvl), .ALWAYS_ON_EN(aon),
    .BATTERY_DOMAIN_GPIO_EN(bgpio), .PERIPH_EN(pen));
  cpsc_sw i_cpsc_sw (.CORE_CLK(clk), .RESETN(rst_n), .pif(i_cpsc_if),
    .CMD_VALID(cmd_valid), .CMD_KIND(kind), .CMD_PS(ps), .CMD_WAKE_EN(wake),
    .CMD_CFG_DONE(cfg), .CMD_BUSY(busy), .CMD_DONE(done), .CMD_FAIL(fail));
  cpsc_props i_cpsc_props (.CORE_CLK(clk), .RESETN(rst_n),
    .req_kind(i_cpsc_if.req_kind), .req_valid(i_cpsc_if.req_valid),
    .wfi(i_cpsc_if.wfi), .req_ack(i_cpsc_if.req_ack),
    .req_nack(i_cpsc_if.req_nack), .cur_ps(i_cpsc_if.cur_ps),
    .cur_mode(i_cpsc_if.cur_mode), .cpu_clk_en(i_cpsc_if.cpu_clk_en),
    .cpu_pwr_en(i_cpsc_if.cpu_pwr_en), .sram_retain(i_cpsc_if.sram_retain),
    .cpu_wants_netproc_awake(i_cpsc_if.cpu_wants_netproc_awake));
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (!ok) begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Predicts whether the controller grants a command.
  function automatic logic exp_ok(input logic [2:0] k, p, c,
      input logic [1:0] n, input logic h, f, input logic [7:0] w);
    logic lp;
    lp = (n == 2'h1 || n == 2'h2) && !h && c != 3'h1;
    case (k)
      3'h1: return p >= 3'h1 && p <= 3'h4 && f;
      3'h2: return lp;
      3'h3: return lp && w != 8'h00;
      default: return n == 2'h3 && !h && w != 8'h00 && f;
    endcase
  endfunction
  task automatic run(input logic [2:0] k, p, input logic [1:0] n,
      input logic h, f, input logic [7:0] w);
    logic ok;
    int   i;
    ok = exp_ok(k, p, model_ps, n, h, f, w);
    np = n;
    hold = h;
    kind = k;
    ps = p;
    wake = w;
    cfg = f;
    tick(5);
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    i = 0;
    while (done !== 1'b1 && fail !== 1'b1 && i < 20) begin
      tick(1);
      i++;
    end
    chk(done === ok && fail === !ok, "command outcome");
    chk(busy === 1'b0, "busy after answer");
    tick(2);
    if (ok && k == 3'h1) begin
      model_ps = p;
      chk(i_cpsc_if.cur_ps === p, "active state");
      chk(sram_lvl === p, "sram level");
      chk(unsup === (p == 3'h2 && n < 2'h2), "unsupported");
    end else if (ok) begin
      chk(i_cpsc_if.cur_mode === 2'(k - 3'h1), "mode");
      chk(i_cpsc_if.cpu_pwr_en === (k == 3'h2), "cpu power");
      chk(pen === (k == 3'h2), "periph enable");
      chk(i_cpsc_if.sram_retain === (k != 3'h4), "retain");
      if (k == 3'h2) begin
        chk(sram_lvl === model_ps && pen === 1'b1, "standby sram");
      end
      if (k != 3'h2) begin
        irq = ~w;
        tick(8);
        chk(i_cpsc_if.cur_mode !== CPSC_MODE_ACTIVE, "stray wake");
      end
      irq = (k == 3'h2) ? 8'h80 : w;
      i = 0;
      while (i_cpsc_if.cur_mode !== CPSC_MODE_ACTIVE && i < 20) begin
        tick(1);
        i++;
      end
      if (k == 3'h4) begin
        model_ps = 3'h4;
      end
      chk(i_cpsc_if.cur_ps === model_ps, "wake state");
      chk(i_cpsc_if.cpu_clk_en === 1'b1, "wake clock");
      irq = 8'h00;
    end
    $display("test kind %0d granted %0d ends", k, ok);
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    tick(20);
    rst_n = 1'b1;
    model_ps = 3'h4;
    tick(5);
    chk(i_cpsc_if.cur_ps === 3'h4, "reset state");
    chk(aon === 1'b1 && bgpio === 1'b1, "always on");
  endtask
  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    do_reset();
    for (int j = 0; j < 8; j++) begin
      run(3'h1, 3'(j), 2'h0, 1'b0, 1'b1, 8'h01);
    end
    run(3'h3, 3'h0, 2'h1, 1'b0, 1'b1, 8'h01);
    run(3'h2, 3'h0, 2'h1, 1'b0, 1'b1, 8'h01);
    run(3'h1, 3'h2, 2'h0, 1'b0, 1'b1, 8'h01);
    run(3'h4, 3'h0, 2'h3, 1'b0, 1'b1, 8'h03);
    run(3'h3, 3'h0, 2'h1, 1'b0, 1'b1, 8'h00);
    run(3'h3, 3'h0, 2'h2, 1'b1, 1'b1, 8'h01);
    do_reset();
    repeat (40) begin
      run(3'(1 + {$random(seed)} % 4), 3'($random(seed)),
        2'($random(seed)), ($random(seed) & 7) == 0,
        ($random(seed) & 7) != 0, 8'(($random(seed) & 8'h7e) | 1));
    end
    final_report();
  end
  initial begin
    #200000;
    error_cnt++;
    final_report();
  end
endmodule
